// ### shared/exc_unit_map.vh
// constants for the interrupt and trap exception unit
`ifndef EXC_UNIT_MAP_VH
`define EXC_UNIT_MAP_VH

// status word layout and reset value
`define SW_TRACE_BIT      15
`define SW_SUPER_BIT      13
`define SW_MASK_HI        10
`define SW_MASK_LO        8
`define SW_RESET          16'h2700

// vector numbers
`define VEC_ILLEGAL       8'h04
`define VEC_ZERO_DIV      8'h05
`define VEC_BOUNDS        8'h06
`define VEC_OVERFLOW      8'h07
`define VEC_PRIVILEGE     8'h08
`define VEC_LINE_A        8'h0a
`define VEC_LINE_F        8'h0b
`define VEC_SPURIOUS      8'h18
`define VEC_AUTO_BASE     8'h18
`define VEC_TRAP_BASE     8'h20

// opcode patterns
`define OP_ILL_A          16'h4afa
`define OP_ILL_B          16'h4afb
`define OP_ILL_C          16'h4afc
`define OP_BREAK          16'h4848
`define OP_BREAK_MASK     16'hfff8
`define OP_ANDI_SW        16'h027c
`define OP_EORI_SW        16'h0a7c
`define OP_ORI_SW         16'h007c
`define OP_MOVE_TO_SW     16'h46c0
`define OP_MOVE_FROM_SW   16'h40c0
`define OP_SW_MOVE_MASK   16'hffc0
`define OP_CTRL_MOVE      16'h4e7a
`define OP_CTRL_MOVE_MASK 16'hfffe
`define OP_ALT_MOVE       16'h0e00
`define OP_ALT_MOVE_MASK  16'hff00
`define OP_USP_MOVE       16'h4e60
`define OP_USP_MOVE_MASK  16'hfff0
`define OP_RESET          16'h4e70
`define OP_STOP           16'h4e72
`define OP_EXC_RETURN     16'h4e73
`define OP_LINE_A         4'ha
`define OP_LINE_F         4'hf

// function codes: acknowledge cycle and idle
`define FC_ACK            3'h7
`define FC_IDLE           3'h0

// register offsets
`define REG_CTRL          8'h00
`define REG_STATE         8'h04
`define REG_LAST          8'h08
`define REG_COUNT         8'h0c

// control register fields and reset
`define CTRL_FMT_BIT      0
`define CTRL_BREAK_BIT    1
`define CTRL_RESET        2'h3

// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### design/interrupt_trap_exception_unit.v
// exception recognition: interrupts, traps, illegal opcodes, privilege checks
`timescale 1ns/100ps
`include "exc_unit_map.vh"

// Function
// RQ1 - request is a level 1 to 7 on three lines; all negated means none
// RQ2 - 3-bit mask in status word blocks levels at or below it
// RQ3 - requests latched pending, tested only between instructions, else postponed
// RQ4 - on taking: copy status, supervisor on, trace off, mask gets level
// RQ5 - acknowledge cycle shows acknowledged level on the address bus
// RQ6 - autovector answer gives internal vector matching the level
// RQ7 - bus fault answer gives spurious vector and short frame
// RQ8 - outside logic asserts bus fault when nobody answers the acknowledge
// RQ9 - acknowledge ends by vector with transfer ack, autovector, or bus fault
// RQ10 - unprogrammed peripheral returns vector 15
// RQ11 - format word holds offset of vector times four, format zero
// RQ12 - interrupt stacks address of next instruction, then loads vector
// RQ13 - level 7 unmaskable; each rise to 7 makes an interrupt
// RQ14 - steady level 7 taken by comparison when mask drops below 7
// RQ15 - trap vector internal, partly from operand; stacks following address
// RQ16 - system call always traps; overflow and bounds checks trap on error
// RQ17 - divides trap when divisor is zero
// RQ18 - opcodes matching nothing legal, and three fixed patterns, trap illegal
// RQ19 - opcode lines 1010 and 1111 trap through separate vectors
// RQ20 - breakpoint opcodes run data-less cycle, then illegal processing
// RQ21 - privileged opcodes in user mode raise privilege violation
// RQ22 - privilege violation stacks offending instruction address
module interrupt_trap_exception_unit (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // interrupt request lines, active low encoded
  input  wire [2:0]  intReqLinesN,
  // core side
  input  wire        boundaryReq,
  input  wire [15:0] nextOpcode,
  input  wire        opcodeLegal,
  input  wire [31:0] pcIn,
  input  wire        swWrite,
  input  wire [15:0] swIn,
  input  wire        trapExec,
  input  wire [3:0]  trapField,
  input  wire        ovfCheckExec,
  input  wire        ovfFlag,
  input  wire        boundsExec,
  input  wire        boundsOut,
  input  wire        divExec,
  input  wire        divisorZero,
  output reg         boundaryGo,
  output reg         excTake,
  output reg  [7:0]  excVector,
  output reg  [31:0] excStackPc,
  output reg  [15:0] excStackSw,
  output reg  [15:0] excFormatWord,
  output reg         excFormatEn,
  output reg  [15:0] statusWord,
  // acknowledge bus cycle
  output reg         ackCycle,
  output reg  [23:0] ackAddr,
  output reg  [2:0]  cycle_function_code,
  input  wire        transfer_ack_n,
  input  wire        periph_addr_valid_n,
  input  wire        autovector_req_n,
  input  wire        bus_fault_n,
  input  wire [7:0]  ackData,
  // axi4-lite slave
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_IACK = 3'b010;
  localparam [2:0] ST_BREAK = 3'b100;

  reg  [2:0]  state_reg;
  reg  [2:0]  pendLvl_reg;
  reg  [2:0]  prevLvl_reg;
  reg         nmiPend_reg;
  reg  [2:0]  ackLvl_reg;
  reg  [15:0] swCopy_reg;
  reg  [31:0] pcHold_reg;
  reg  [1:0]  ctrl_reg;
  reg  [7:0]  lastVec_reg;
  reg  [15:0] count_reg;
  reg  [7:0]  awAddr_reg;
  reg         awHeld_reg;
  reg  [31:0] wData_reg;
  reg         wHeld_reg;
  reg         wStrb0_reg;

  function match;
    input [15:0] op;
    input [15:0] pat;
    input [15:0] msk;
    begin
      match = ((op & msk) == pat);
    end
  endfunction

  function [15:0] formatWord;
    input [7:0] vec;
    begin
      formatWord = {4'h0, 2'h0, vec, 2'h0}; // RQ11
    end
  endfunction

  wire [2:0] reqLvl   = ~intReqLinesN; // RQ1
  wire [2:0] swMask   = statusWord[`SW_MASK_HI:`SW_MASK_LO];
  wire       superOn  = statusWord[`SW_SUPER_BIT];
  wire       nmiEdge  = (pendLvl_reg == 3'h7) && (prevLvl_reg != 3'h7); // RQ13
  wire       intReady = nmiPend_reg || (pendLvl_reg > swMask); // RQ2 RQ14
  wire [2:0] takeLvl  = nmiPend_reg ? 3'h7 : pendLvl_reg;

  wire isBreak = match(nextOpcode, `OP_BREAK, `OP_BREAK_MASK);
  wire isIll   = !opcodeLegal || isBreak || (nextOpcode == `OP_ILL_A) ||
                 (nextOpcode == `OP_ILL_B) || (nextOpcode == `OP_ILL_C); // RQ18
  wire isLineA = (nextOpcode[15:12] == `OP_LINE_A); // RQ19
  wire isLineF = (nextOpcode[15:12] == `OP_LINE_F); // RQ19
  wire isPriv  = (nextOpcode == `OP_ANDI_SW) || (nextOpcode == `OP_EORI_SW) ||
                 (nextOpcode == `OP_ORI_SW) || (nextOpcode == `OP_RESET) ||
                 (nextOpcode == `OP_STOP) || (nextOpcode == `OP_EXC_RETURN) ||
                 match(nextOpcode, `OP_MOVE_TO_SW, `OP_SW_MOVE_MASK) ||
                 match(nextOpcode, `OP_MOVE_FROM_SW, `OP_SW_MOVE_MASK) ||
                 match(nextOpcode, `OP_CTRL_MOVE, `OP_CTRL_MOVE_MASK) ||
                 match(nextOpcode, `OP_ALT_MOVE, `OP_ALT_MOVE_MASK) ||
                 match(nextOpcode, `OP_USP_MOVE, `OP_USP_MOVE_MASK); // RQ21

  wire grp2 = trapExec || (ovfCheckExec && ovfFlag) ||
              (boundsExec && boundsOut) || (divExec && divisorZero); // RQ16 RQ17
  wire ackEnd = !transfer_ack_n || !periph_addr_valid_n ||
                !autovector_req_n || !bus_fault_n;

  //////////////////////////////////////////////////////////////////////////////
  // exception selection

  reg        fire;
  reg        goIack;
  reg        goBreak;
  reg        proceed;
  reg [7:0]  fireVec;
  always @* begin
    fire    = 1'b0;
    goIack  = 1'b0;
    goBreak = 1'b0;
    proceed = 1'b0;
    fireVec = `VEC_ILLEGAL;
    case (state_reg)
      ST_IDLE: begin
        if (grp2) begin
          fire = 1'b1;
          if (trapExec)
            fireVec = `VEC_TRAP_BASE + {4'h0, trapField}; // RQ15
          else if (ovfCheckExec && ovfFlag)
            fireVec = `VEC_OVERFLOW; // RQ16
          else if (boundsExec && boundsOut)
            fireVec = `VEC_BOUNDS; // RQ16
          else
            fireVec = `VEC_ZERO_DIV; // RQ17
        end else if (boundaryReq) begin // RQ3
          if (intReady)
            goIack = 1'b1;
          else if (isBreak && ctrl_reg[`CTRL_BREAK_BIT])
            goBreak = 1'b1; // RQ20
          else if (isIll || isLineA || isLineF || (isPriv && !superOn)) begin
            fire = 1'b1;
            if (isIll)
              fireVec = `VEC_ILLEGAL; // RQ18
            else if (isLineA)
              fireVec = `VEC_LINE_A; // RQ19
            else if (isLineF)
              fireVec = `VEC_LINE_F; // RQ19
            else
              fireVec = `VEC_PRIVILEGE; // RQ21
          end else
            proceed = 1'b1; // RQ3
        end
      end
      ST_IACK: begin
        if (ackEnd) begin
          fire = 1'b1;
          if (!bus_fault_n)
            fireVec = `VEC_SPURIOUS; // RQ7
          else if (!transfer_ack_n)
            fireVec = ackData;
          else
            fireVec = `VEC_AUTO_BASE + {5'h00, ackLvl_reg}; // RQ6
        end
      end
      ST_BREAK: begin
        if (ackEnd) begin
          fire    = 1'b1;
          fireVec = `VEC_ILLEGAL; // RQ20
        end
      end
      default: begin
        fire = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // pending requests, status word and sequencing

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg           <= ST_IDLE;
      pendLvl_reg         <= 3'h0;
      prevLvl_reg         <= 3'h0;
      nmiPend_reg         <= 1'b0;
      ackLvl_reg          <= 3'h0;
      swCopy_reg          <= 16'h0000;
      pcHold_reg          <= 32'h0000_0000;
      statusWord          <= `SW_RESET;
      boundaryGo          <= 1'b0;
      excTake             <= 1'b0;
      excVector           <= 8'h00;
      excStackPc          <= 32'h0000_0000;
      excStackSw          <= 16'h0000;
      excFormatWord       <= 16'h0000;
      excFormatEn         <= 1'b0;
      ackCycle            <= 1'b0;
      ackAddr             <= 24'h00_0000;
      cycle_function_code <= `FC_IDLE;
      lastVec_reg         <= 8'h00;
      count_reg           <= 16'h0000;
    end else begin
      pendLvl_reg <= reqLvl; // RQ3
      prevLvl_reg <= pendLvl_reg;
      boundaryGo  <= proceed;
      excTake     <= fire;
      if (nmiEdge)
        nmiPend_reg <= 1'b1; // RQ13
      else if (goIack && takeLvl == 3'h7)
        nmiPend_reg <= 1'b0;
      if (swWrite && state_reg == ST_IDLE && !fire && !goIack && !goBreak)
        statusWord <= swIn; // RQ14
      if (goIack || goBreak || (fire && state_reg == ST_IDLE)) begin
        swCopy_reg <= statusWord; // RQ4
        pcHold_reg <= pcIn; // RQ12 RQ15 RQ22
        statusWord[`SW_SUPER_BIT] <= 1'b1; // RQ4
        statusWord[`SW_TRACE_BIT] <= 1'b0; // RQ4
      end
      if (goIack) begin
        statusWord[`SW_MASK_HI:`SW_MASK_LO] <= takeLvl; // RQ4
        ackLvl_reg          <= takeLvl;
        ackCycle            <= 1'b1;
        ackAddr             <= {20'h0_0000, takeLvl, 1'b0}; // RQ5
        cycle_function_code <= `FC_ACK;
        state_reg           <= ST_IACK;
      end else if (goBreak) begin
        ackCycle            <= 1'b1;
        ackAddr             <= 24'h00_0000; // RQ20
        cycle_function_code <= `FC_ACK;
        state_reg           <= ST_BREAK;
      end
      if (fire) begin
        excVector     <= fireVec;
        excStackPc    <= (state_reg == ST_IDLE) ? pcIn : pcHold_reg;
        excStackSw    <= (state_reg == ST_IDLE) ? statusWord : swCopy_reg;
        excFormatWord <= formatWord(fireVec); // RQ11
        excFormatEn   <= ctrl_reg[`CTRL_FMT_BIT];
        lastVec_reg   <= fireVec;
        count_reg     <= count_reg + 16'h0001;
        ackCycle            <= 1'b0;
        ackAddr             <= 24'h00_0000;
        cycle_function_code <= `FC_IDLE;
        state_reg           <= ST_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite register access

  wire       doWrite  = awHeld_reg && wHeld_reg && !bvalid;
  wire [7:0] readAddr = araddr;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awready    <= 1'b0;
      wready     <= 1'b0;
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h0000_0000;
      wStrb0_reg <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      ctrl_reg   <= `CTRL_RESET;
      arready    <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= `RESP_OKAY;
    end else begin
      awready <= !awHeld_reg && !awready && awvalid;
      wready  <= !wHeld_reg && !wready && wvalid;
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb0_reg <= wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        if (awAddr_reg == `REG_CTRL) begin
          bresp <= `RESP_OKAY;
          if (wStrb0_reg)
            ctrl_reg <= wData_reg[1:0];
        end else if (awAddr_reg == `REG_STATE || awAddr_reg == `REG_LAST ||
                     awAddr_reg == `REG_COUNT)
          bresp <= `RESP_OKAY;
        else
          bresp <= `RESP_SLVERR;
      end else if (bvalid && bready)
        bvalid <= 1'b0;
      arready <= !arready && !rvalid && arvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `RESP_OKAY;
        case (readAddr)
          `REG_CTRL:  rdata <= {30'h0000_0000, ctrl_reg};
          `REG_STATE: rdata <= {6'h00, nmiPend_reg, pendLvl_reg, 3'h0, state_reg,
                                statusWord};
          `REG_LAST:  rdata <= {24'h00_0000, lastVec_reg};
          `REG_COUNT: rdata <= {16'h0000, count_reg};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

endmodule // interrupt_trap_exception_unit

// ### verif/exc_unit_chk.sv
// concurrent checks on the exception unit ports
`timescale 1ns/100ps
module exc_unit_chk (
  // clock and reset
  input wire        clk,
  input wire        rst_b,
  // core side
  input wire        boundaryReq,
  input wire [31:0] pcIn,
  input wire        divExec,
  input wire        divisorZero,
  input wire        boundaryGo,
  input wire        excTake,
  input wire [7:0]  excVector,
  input wire [31:0] excStackPc,
  input wire [15:0] excFormatWord,
  input wire [15:0] statusWord,
  // acknowledge cycle
  input wire        ackCycle,
  input wire [23:0] ackAddr,
  input wire [2:0]  cycle_function_code,
  input wire        autovector_req_n,
  input wire        bus_fault_n
);
  reg [2:0] ackLvl;
  always @(posedge clk) begin
    ackLvl <= ackAddr[3:1];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  fc_ack_a:
    assert property (ackCycle |-> cycle_function_code == 3'h7) else $error("fc not 7");
  fc_idle_a:
    assert property (!ackCycle |-> cycle_function_code == 3'h0) else $error("fc not idle");
  ack_status_a:
    assert property ($rose(ackCycle) && ackAddr[3:1] != 3'h0 |->
      statusWord[10:8] == ackAddr[3:1] && statusWord[13] && !statusWord[15])
      else $error("status not set on ack");
  take_super_a:
    assert property (excTake |-> ##[0:1] (statusWord[13] && !statusWord[15]))
      else $error("take not supervisor");
  fmt_word_a:
    assert property (excTake |-> excFormatWord == {6'h00, excVector, 2'h0})
      else $error("format word bad");
  spurious_vec_a:
    assert property (ackCycle && !bus_fault_n && ackAddr[3:1] != 3'h0 |=>
      excTake && excVector == 8'h18) else $error("spurious vector bad");
  auto_vec_a:
    assert property (ackCycle && !autovector_req_n && bus_fault_n && ackAddr[3:1] != 3'h0
      |=> excTake && excVector == 8'h18 + {5'h00, ackLvl}) else $error("auto vector bad");
  zero_div_a:
    assert property (divExec && divisorZero && !ackCycle && !boundaryReq && !excTake |=>
      excTake && excVector == 8'h05 && excStackPc == $past(pcIn)) else $error("zero div bad");
  bnd_answer_a:
    assert property ($rose(boundaryReq) && !ackCycle |=> boundaryGo || excTake || ackCycle)
      else $error("boundary not answered");
  cover property ($rose(ackCycle));
  cover property (excTake && excVector == 8'h18);
  cover property (boundaryGo);
endmodule // exc_unit_chk
bind interrupt_trap_exception_unit exc_unit_chk u_chk (.*);

// ### verif/irq_peripheral.sv
// interrupting peripheral and acknowledge termination model
`timescale 1ns/100ps
module irq_peripheral #(
  parameter [7:0] VEC_ANSWER = 8'h0f
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // bench control: level, ending kind, wait cycles
  input  wire [2:0] level,
  input  wire [1:0] mode,
  input  wire [2:0] delay,
  // request and acknowledge
  input  wire       ackCycle,
  output wire [2:0] intReqLinesN,
  output wire       transfer_ack_n,
  output wire       periph_addr_valid_n,
  output wire       autovector_req_n,
  output wire       bus_fault_n,
  output wire [7:0] ackData
);
  reg  [2:0] waitCnt;
  wire       answer;
  assign intReqLinesN = ~level;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      waitCnt <= 3'h0;
    else if (!ackCycle)
      waitCnt <= 3'h0;
    else if (!answer)
      waitCnt <= waitCnt + 3'h1;
  end
  // one ending held until the cycle closes
  assign answer              = ackCycle && (waitCnt >= delay);
  assign transfer_ack_n      = !(answer && mode == 2'h0);
  assign autovector_req_n    = !(answer && mode == 2'h1);
  assign periph_addr_valid_n = !(answer && mode == 2'h2);
  assign bus_fault_n         = !(answer && mode == 2'h3);
  assign ackData = (answer && mode == 2'h0) ? VEC_ANSWER : ~VEC_ANSWER;
endmodule // irq_peripheral

// ### verif/test_interrupt_trap_exception_unit.sv
// testbench for the interrupt and trap exception unit
`timescale 1ns/100ps
module test_interrupt_trap_exception_unit;
  reg         clk = 1'b0, rst_b = 1'b0, boundaryReq = 1'b0, opcodeLegal = 1'b0, swWrite = 1'b0;
  reg         trapExec = 1'b0, ovfCheckExec = 1'b0, boundsExec = 1'b0, divExec = 1'b0;
  reg         ovfFlag = 1'b0, boundsOut = 1'b0, divisorZero = 1'b0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [15:0] nextOpcode = 16'h0000, swIn = 16'h0000;
  reg  [31:0] pcIn = 32'h00001000, wdata = 32'h0, rd;
  reg  [3:0]  trapField = 4'h5, wstrb = 4'hf;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [2:0]  level = 3'h0, delay = 3'h0;
  reg  [1:0]  mode = 2'h1, rr;
  reg  [23:0] seenAddr;
  reg  [15:0] privOps [0:10] = '{16'h027c, 16'h0a7c, 16'h007c, 16'h46c0, 16'h40c0,
                                 16'h4e7a, 16'h0e00, 16'h4e60, 16'h4e70, 16'h4e72, 16'h4e73};
  integer     fails = 0, comparisons = 0, i;
  wire        boundaryGo, excTake, excFormatEn, ackCycle, awready, wready, bvalid;
  wire        arready, rvalid, transfer_ack_n, periph_addr_valid_n, autovector_req_n, bus_fault_n;
  wire [7:0]  excVector, ackData;
  wire [31:0] excStackPc, rdata;
  wire [15:0] excStackSw, excFormatWord, statusWord;
  wire [23:0] ackAddr;
  wire [2:0]  cycle_function_code, intReqLinesN;
  wire [1:0]  bresp, rresp;
  interrupt_trap_exception_unit i_dut (.*);
  irq_peripheral i_periph (.*);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input ok);
    begin
      comparisons = comparisons + 1;
      if (!ok) begin
        fails = fails + 1;
        $display("wrong value at %0t: output mismatch", $time);
      end
    end
  endtask
  task final_report;
    begin
      if (fails == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      while (n != 99) begin
        @(posedge clk);
        n = n + 1;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          bready <= 1'b0;
          rr = bresp;
          n = 99;
        end
      end
      chk(n == 99 && rr === er);
    end
  endtask
  task axr(input [7:0] a, input [31:0] exp, input [1:0] er);
    integer n;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      while (n != 99) begin
        @(posedge clk);
        n = n + 1;
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          rready <= 1'b0;
          rd = rdata;
          rr = rresp;
          n = 99;
        end
      end
      chk(n == 99 && rd === exp && rr === er);
    end
  endtask
  task sw(input [15:0] v);
    begin
      @(posedge clk);
      swWrite <= 1'b1;
      swIn <= v;
      @(posedge clk);
      swWrite <= 1'b0;
    end
  endtask
  // ev of zero means the instruction runs
  task bnd(input [15:0] op, input lgl, input [7:0] ev);
    integer n;
    begin
      @(posedge clk);
      boundaryReq <= 1'b1;
      nextOpcode <= op;
      opcodeLegal <= lgl;
      pcIn <= pcIn + 32'h4;
      seenAddr = 24'hffffff;
      n = 0;
      while (n < 30) begin
        @(posedge clk);
        #1;
        n = n + 1;
        if (ackCycle) seenAddr = ackAddr;
        if (boundaryGo || excTake) n = 99;
      end
      boundaryReq <= 1'b0;
      chk(n == 99 && excTake === (ev != 8'h00));
      if (ev != 8'h00) chk(excVector === ev && excStackPc === pcIn);
    end
  endtask
  task irq(input [2:0] lvl, input [1:0] m, input [7:0] ev);
    begin
      level <= lvl;
      mode <= m;
      repeat (3) @(posedge clk);
      bnd(16'h4e71, 1'b1, ev);
      if (ev != 8'h00) chk(statusWord[10:8] === lvl && seenAddr[3:1] === lvl);
    end
  endtask
  task g2(input [3:0] sel, input cond, input [7:0] ev);
    begin
      @(posedge clk);
      {trapExec, ovfCheckExec, boundsExec, divExec} <= sel;
      {ovfFlag, boundsOut, divisorZero} <= {3{cond}};
      pcIn <= pcIn + 32'h2;
      @(posedge clk);
      {trapExec, ovfCheckExec, boundsExec, divExec} <= 4'h0;
      #1;
      chk(excTake === (ev != 8'h00));
      if (ev != 8'h00) chk(excVector === ev && excStackPc === pcIn);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fails = fails + 1;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(statusWord === 16'h2700 && cycle_function_code === 3'h0);
    axr(8'h00, 32'h3, 2'h0);
    axw(8'h00, 32'h0, 2'h0);
    axr(8'h00, 32'h0, 2'h0);
    bnd(16'h4848, 1'b1, 8'h04);
    chk(seenAddr === 24'hffffff && excFormatEn === 1'b0);
    axw(8'h10, 32'h5, 2'h2);
    axr(8'h10, 32'h0, 2'h2);
    axw(8'h00, 32'h3, 2'h0);
    sw(16'ha300);
    bnd(16'h4e71, 1'b1, 8'h00);
    irq(3'h3, 2'h1, 8'h00);
    irq(3'h5, 2'h1, 8'h1d);
    chk(excFormatWord === 16'h0074 && excStackSw === 16'ha300 && statusWord[15] === 1'b0);
    chk(excFormatEn === 1'b1);
    sw(16'h2000);
    irq(3'h2, 2'h3, 8'h18);
    sw(16'h2000);
    delay <= 3'h5;
    irq(3'h4, 2'h0, 8'h0f);
    delay <= 3'h0;
    sw(16'h2000);
    irq(3'h1, 2'h2, 8'h19);
    sw(16'h2700);
    irq(3'h7, 2'h1, 8'h1f);
    bnd(16'h4e71, 1'b1, 8'h00);
    sw(16'h2600);
    bnd(16'h4e71, 1'b1, 8'h1f);
    level <= 3'h0;
    sw(16'h2000);
    for (i = 0; i < 3; i = i + 1) bnd(16'h4afa + i[15:0], 1'b1, 8'h04);
    bnd(16'h4afd, 1'b0, 8'h04);
    bnd(16'ha123, 1'b1, 8'h0a);
    bnd(16'hf456, 1'b1, 8'h0b);
    mode <= 2'h2;
    bnd(16'h484d, 1'b1, 8'h04);
    chk(seenAddr === 24'h000000);
    for (i = 0; i < 11; i = i + 1) begin
      sw(16'h0000);
      bnd(privOps[i], 1'b1, 8'h08);
    end
    sw(16'h2000);
    bnd(16'h4e73, 1'b1, 8'h00);
    g2(4'h8, 1'b0, 8'h25);
    g2(4'h4, 1'b1, 8'h07);
    g2(4'h4, 1'b0, 8'h00);
    g2(4'h2, 1'b1, 8'h06);
    g2(4'h2, 1'b0, 8'h00);
    g2(4'h1, 1'b1, 8'h05);
    g2(4'h1, 1'b0, 8'h00);
    axr(8'h08, 32'h05, 2'h0);
    axr(8'h0c, 32'h1d, 2'h0);
    final_report;
  end
endmodule // test_interrupt_trap_exception_unit
